/* File: rtl/cgs_pkg.sv */
package cgs_pkg;
	// ---------------------------------------------------------------
	// Register offsets on the register access port
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_GAIN = 8'h01;
	localparam logic [7:0] ADDR_WAVEFORM_MODE_REG = 8'h02;
	localparam logic [7:0] ADDR_WAVDATA = 8'h03;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h05;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int GAIN_IPGA_LSB = 0;
	localparam int GAIN_RANGE_LSB = 3;
	localparam int GAIN_VPGA_LSB = 5;
	localparam int GAIN_INTEG_BIT = 7;
	localparam int WAV_SRC_LSB = 0;
	localparam int WAV_PHASE_LSB = 3;
	localparam int WAV_RATE_LSB = 5;
	localparam int MASK_WAVE_BIT = 0;
	localparam int STAT_WAVE_BIT = 0;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [7:0] WAVEFORM_MODE_REG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [2:0] SRC_CURRENT = 3'h0;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// ---------------------------------------------------------------
	// Sample format and timing
	// ---------------------------------------------------------------
	localparam int SAMPLE_W = 24;
	localparam int NUM_PHASES = 3;
	localparam logic [23:0] FS_POS = 24'h28_51EC;
	localparam logic [23:0] FS_NEG = 24'hD7_AE14;
	localparam int INTEG_SHIFT = 4;
	localparam int CLK_PERIOD_NS = 100;
	localparam int BASE_PERIOD_NS = 38400;
	localparam int BASE_TICK_CYCLES = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: rtl/cgs_path_if.sv */
`timescale 1ns/1ps
interface cgs_path_if;
	logic integ_en;
	logic in_valid;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] in_data;
	logic out_valid;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] out_data;
	modport ctrl (output integ_en, output in_valid, output in_data,
		input out_valid, input out_data);
	modport path (input integ_en, input in_valid, input in_data,
		output out_valid, output out_data);
endinterface

/* File: rtl/cgs_phase_path.sv */
`timescale 1ns/1ps
module cgs_phase_path (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	cgs_path_if.path pif
);
	// ---------------------------------------------------------------
	// Per-phase integrator and full-scale limiter
	// ---------------------------------------------------------------
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] integ;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] next_integ;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] out_data;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] next_out_data;
	logic out_valid;
	logic next_out_valid;

	function automatic logic [23:0] limit_fs(input logic signed [23:0] v);
		if (v > $signed(cgs_pkg::FS_POS)) begin
			limit_fs = cgs_pkg::FS_POS;
		end else if (v < $signed(cgs_pkg::FS_NEG)) begin
			limit_fs = cgs_pkg::FS_NEG;
		end else begin
			limit_fs = v;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < cgs_pkg::NUM_PHASES; g++) begin : g_phase
			logic signed [23:0] x;
			logic signed [23:0] y;
			logic signed [23:0] y_step;
			// Leaky accumulator keeps the integrator from running away on offset
			always_comb begin
				x = $signed(pif.in_data[g]);
				y = $signed(integ[g]);
				y_step = y - (y >>> cgs_pkg::INTEG_SHIFT) + (x >>> cgs_pkg::INTEG_SHIFT);
				next_integ[g] = integ[g];
				next_out_data[g] = out_data[g];
				if (pif.in_valid) begin
					next_integ[g] = pif.integ_en ? y_step : 24'h00_0000;
					next_out_data[g] = limit_fs(pif.integ_en ? y_step : x);
				end
			end
		end
	endgenerate

	always_comb begin
		next_out_valid = pif.in_valid;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			integ <= '0;
			out_data <= '0;
			out_valid <= 1'b0;
		end else begin
			integ <= next_integ;
			out_data <= next_out_data;
			out_valid <= next_out_valid;
		end
	end

	assign pif.out_data = out_data;
	assign pif.out_valid = out_valid;
endmodule

/* File: rtl/cgs_gain_sampler.sv */
`timescale 1ns/1ps
// Behaviour
// - Current amplifier gain 1/2/4 comes from gain register bits 1:0.
// - Gain register bits 4:3 choose current full scale 0.5/0.25/0.125 V.
// - Voltage amplifier gain 1/2/4 comes from gain register bits 6:5.
// - One gain setting serves all three phases of a channel.
// - Gain register bit 7 enables the current integrator, clear bypasses it.
// - Waveform samples are signed 24-bit words at no more than 26.04 kSPS.
// - Current samples are limited to 0x2851EC and 0xD7AE14 at full scale.
// - Source select 000 routes current samples to waveform data at fixed rate.
// - Phase select field picks which phase feeds waveform data.
// - Energy path keeps running while waveform sampling is active.
// - Rate select bits 6:5 give 26.04, 13.02, 6.51 or 3.25 kSPS.
// - With sample-ready mask set, interrupt goes low on each new sample.
// - A sample is read as three bytes, most significant byte first.
// - Interrupt stays low until the host reads the status register or clears the mask.
// - Interrupt is active-low open drain, pulled low only while pending.
module cgs_gain_sampler #(
	parameter int TICK_CYCLES = cgs_pkg::BASE_TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic cur_adc_valid_i,
	input wire logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] cur_adc_i,
	output logic cur_valid_o,
	output logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] cur_sample_o,
	output logic [1:0] cur_pga_gain_o,
	output logic [1:0] cur_range_o,
	output logic [1:0] volt_pga_gain_o,
	output logic integ_en_o,
	output logic [23:0] waveform_data_o,
	output logic irq_n_o,
	output logic irq_n_oe_o
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] channel_gain_config;
	logic [7:0] next_channel_gain_config;
	logic [7:0] waveform_mode_reg;
	logic [7:0] next_waveform_mode_reg;
	logic [7:0] irq_mask;
	logic [7:0] next_irq_mask;
	logic [2:0] waveform_source_select;
	logic [1:0] sample_phase_select;
	logic [1:0] sample_rate_select;
	logic sample_ready_irq_mask;

	always_comb begin
		next_channel_gain_config = channel_gain_config;
		next_waveform_mode_reg = waveform_mode_reg;
		next_irq_mask = irq_mask;
		if (reg_wr_i) begin
			case (reg_addr_i)
				cgs_pkg::ADDR_GAIN: next_channel_gain_config = reg_wdata_i;
				cgs_pkg::ADDR_WAVEFORM_MODE_REG: next_waveform_mode_reg = reg_wdata_i;
				cgs_pkg::ADDR_MASK: next_irq_mask = reg_wdata_i;
				default: next_irq_mask = irq_mask;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			channel_gain_config <= cgs_pkg::GAIN_RESET;
			waveform_mode_reg <= cgs_pkg::WAVEFORM_MODE_REG_RESET;
			irq_mask <= cgs_pkg::MASK_RESET;
		end else begin
			channel_gain_config <= next_channel_gain_config;
			waveform_mode_reg <= next_waveform_mode_reg;
			irq_mask <= next_irq_mask;
		end
	end

	// One field per channel drives every phase of that channel
	assign cur_pga_gain_o = channel_gain_config[cgs_pkg::GAIN_IPGA_LSB +: 2];
	assign cur_range_o = channel_gain_config[cgs_pkg::GAIN_RANGE_LSB +: 2];
	assign volt_pga_gain_o = channel_gain_config[cgs_pkg::GAIN_VPGA_LSB +: 2];
	assign integ_en_o = channel_gain_config[cgs_pkg::GAIN_INTEG_BIT];
	assign waveform_source_select = waveform_mode_reg[cgs_pkg::WAV_SRC_LSB +: 3];
	assign sample_phase_select = waveform_mode_reg[cgs_pkg::WAV_PHASE_LSB +: 2];
	assign sample_rate_select = waveform_mode_reg[cgs_pkg::WAV_RATE_LSB +: 2];
	assign sample_ready_irq_mask = irq_mask[cgs_pkg::MASK_WAVE_BIT];

	// ---------------------------------------------------------------
	// Current path, runs on every converter result
	// ---------------------------------------------------------------
	cgs_path_if pif ();
	assign pif.integ_en = channel_gain_config[cgs_pkg::GAIN_INTEG_BIT];
	assign pif.in_valid = cur_adc_valid_i;
	assign pif.in_data = cur_adc_i;
	assign cur_valid_o = pif.out_valid;
	assign cur_sample_o = pif.out_data;

	cgs_phase_path u_path (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.pif(pif)
	);

	// ---------------------------------------------------------------
	// Sample rate timebase
	// ---------------------------------------------------------------
	logic [15:0] tick_cnt;
	logic [15:0] next_tick_cnt;
	logic [2:0] div_cnt;
	logic [2:0] next_div_cnt;
	logic base_tick;
	logic [2:0] div_mask;
	logic capture;

	always_comb begin
		base_tick = (tick_cnt == 16'(TICK_CYCLES - 1));
		next_tick_cnt = base_tick ? 16'h0000 : tick_cnt + 16'h0001;
		next_div_cnt = base_tick ? div_cnt + 3'h1 : div_cnt;
		div_mask = 3'((4'h1 << sample_rate_select) - 4'h1);
		capture = base_tick && ((div_cnt & div_mask) == 3'h0)
			&& (waveform_source_select == cgs_pkg::SRC_CURRENT)
			&& (sample_phase_select != 2'h3);
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt <= 16'h0000;
			div_cnt <= 3'h0;
		end else begin
			tick_cnt <= next_tick_cnt;
			div_cnt <= next_div_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Waveform capture, byte readout and interrupt
	// ---------------------------------------------------------------
	logic [23:0] waveform_data_reg;
	logic [23:0] next_waveform_data_reg;
	logic [1:0] byte_idx;
	logic [1:0] next_byte_idx;
	logic wave_pending;
	logic next_wave_pending;
	logic irq_oe;
	logic next_irq_oe;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic rd_status;

	always_comb begin
		rd_status = reg_rd_i && (reg_addr_i == cgs_pkg::ADDR_STATUS);
		next_waveform_data_reg = waveform_data_reg;
		next_byte_idx = byte_idx;
		if (reg_rd_i && reg_addr_i == cgs_pkg::ADDR_WAVDATA) begin
			next_byte_idx = (byte_idx == 2'h0) ? 2'h2 : byte_idx - 2'h1;
		end
		if (capture) begin
			next_waveform_data_reg = pif.out_data[sample_phase_select];
			next_byte_idx = 2'h2;
		end
		// A sample arriving with the status read still raises the flag
		next_wave_pending = capture || (wave_pending && !rd_status);
		// Mask taken from its next value so the pin never drives for a masked event
		next_irq_oe = next_wave_pending && next_irq_mask[cgs_pkg::MASK_WAVE_BIT];
		next_rdata = cgs_pkg::UNMAPPED_DATA;
		if (reg_rd_i) begin
			case (reg_addr_i)
				cgs_pkg::ADDR_GAIN: next_rdata = channel_gain_config;
				cgs_pkg::ADDR_WAVEFORM_MODE_REG: next_rdata = waveform_mode_reg;
				cgs_pkg::ADDR_WAVDATA: next_rdata = waveform_data_reg[byte_idx*8 +: 8];
				cgs_pkg::ADDR_MASK: next_rdata = irq_mask;
				cgs_pkg::ADDR_STATUS: next_rdata = 8'(wave_pending) << cgs_pkg::STAT_WAVE_BIT;
				default: next_rdata = cgs_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			waveform_data_reg <= 24'h00_0000;
			byte_idx <= 2'h2;
			wave_pending <= 1'b0;
			irq_oe <= 1'b0;
			rdata <= 8'h00;
		end else begin
			waveform_data_reg <= next_waveform_data_reg;
			byte_idx <= next_byte_idx;
			wave_pending <= next_wave_pending;
			irq_oe <= next_irq_oe;
			rdata <= next_rdata;
		end
	end

	assign waveform_data_o = waveform_data_reg;
	assign reg_rdata_o = rdata;
	assign irq_n_oe_o = irq_oe;
	assign irq_n_o = 1'b0;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [15:0] gap_cnt;
	logic seen_capture;
	logic [1:0] prev_rate;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_cnt <= 16'h0000;
			seen_capture <= 1'b0;
			prev_rate <= 2'h0;
		end else begin
			gap_cnt <= capture ? 16'h0000 : gap_cnt + 16'h0001;
			seen_capture <= seen_capture | capture;
			prev_rate <= capture ? sample_rate_select : prev_rate;
		end
	end

	a_ipga_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == cgs_pkg::ADDR_GAIN) |=> cur_pga_gain_o == $past(reg_wdata_i[1:0]))
		else $error("current gain not taken from gain bits 1:0");
	a_range_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == cgs_pkg::ADDR_GAIN) |=> cur_range_o == $past(reg_wdata_i[4:3]))
		else $error("range not taken from gain bits 4:3");
	a_vpga_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == cgs_pkg::ADDR_GAIN) |=> volt_pga_gain_o == $past(reg_wdata_i[6:5]))
		else $error("voltage gain not taken from gain bits 6:5");
	a_bypass_path: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(cur_adc_valid_i && !integ_en_o && $signed(cur_adc_i[0]) <= $signed(cgs_pkg::FS_POS)
		&& $signed(cur_adc_i[0]) >= $signed(cgs_pkg::FS_NEG)) |=> cur_sample_o[0] == $past(cur_adc_i[0]))
		else $error("bypassed sample altered");
	a_sample_limit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$signed(waveform_data_o) <= $signed(cgs_pkg::FS_POS) && $signed(waveform_data_o) >= $signed(cgs_pkg::FS_NEG))
		else $error("waveform sample beyond full scale");
	a_energy_path: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		cur_adc_valid_i |=> cur_valid_o)
		else $error("current path stalled");
	a_source_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		capture |-> waveform_source_select == cgs_pkg::SRC_CURRENT)
		else $error("capture outside current source mode");
	a_phase_pick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		capture |=> waveform_data_o == $past(cur_sample_o[sample_phase_select]))
		else $error("wrong phase captured");
	a_rate_spacing: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(capture && seen_capture && prev_rate == sample_rate_select)
		|-> gap_cnt == 16'((TICK_CYCLES << sample_rate_select) - 1))
		else $error("sample spacing wrong for rate");
	a_irq_on_sample: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(capture && sample_ready_irq_mask && !(reg_wr_i && reg_addr_i == cgs_pkg::ADDR_MASK))
		|=> irq_n_oe_o)
		else $error("no interrupt on new sample");
	a_irq_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(irq_n_oe_o && !rd_status && !reg_wr_i) |=> irq_n_oe_o)
		else $error("interrupt released without status read");
	a_irq_pending: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		irq_n_oe_o |-> (wave_pending && sample_ready_irq_mask && irq_n_o == 1'b0))
		else $error("interrupt driven without pending event");
	a_msb_first: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(reg_rd_i && reg_addr_i == cgs_pkg::ADDR_WAVDATA && byte_idx == 2'h2)
		|=> reg_rdata_o == $past(waveform_data_o[23:16]))
		else $error("first byte not most significant");

	c_capture_irq: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		capture && sample_ready_irq_mask);
	c_three_bytes: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(reg_rd_i && reg_addr_i == cgs_pkg::ADDR_WAVDATA)[*3]);
	c_status_clear: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		irq_n_oe_o && rd_status);
	c_slow_rate: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		capture && sample_rate_select == 2'h3 && integ_en_o);
endmodule

/* File: sim/cgs_host_model.sv */
`timescale 1ns/1ps
module cgs_host_model (
	input wire logic sys_clk_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic irq_n_i,
	input wire logic irq_n_oe_i,
	output logic irq_line_o
);
	// ---------------------------------------------------------------
	// Interrupt line with board pull-up
	// ---------------------------------------------------------------
	assign irq_line_o = irq_n_oe_i ? irq_n_i : 1'b1;

	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// ---------------------------------------------------------------
	// Register access
	// ---------------------------------------------------------------
	// Released address and data are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge sys_clk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		reg_rd_o = 1'b1;
		reg_addr_o = a;
		@(negedge sys_clk_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask

	// Sample arrives as three bytes, top byte first
	task automatic rd_sample(output logic [23:0] s);
		logic [7:0] b;
		s = 24'h00_0000;
		for (int i = 0; i < 3; i++) begin
			rd(cgs_pkg::ADDR_WAVDATA, b);
			s = {s[15:0], b};
		end
	endtask

	// Reading status is the only way to clear the pending flag; clearing the mask also releases the pin
	task automatic ack(output logic [7:0] d);
		rd(cgs_pkg::ADDR_STATUS, d);
	endtask
endmodule

/* File: sim/current_channel_gain_and_sampling_bench.sv */
`timescale 1ns/1ps
module current_channel_gain_and_sampling_bench;
	localparam int TICK = 8;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr, rd, irq_n, irq_oe, irq_line, adc_v, cur_v, integ;
	logic [7:0] addr, wdata, rdata, d;
	logic [1:0] ipga, irange, vpga;
	logic [23:0] wave, s;
	logic [cgs_pkg::NUM_PHASES-1:0][cgs_pkg::SAMPLE_W-1:0] adc_d, cur_s;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int t0;
	logic [7:0] gains [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'hC0, 8'h00};
	// Bypassed phase values last fed in, per phase
	logic [23:0] ph [3] = '{24'h11_1111, 24'h0A_BCDE, 24'hF2_3456};

	always #50 sys_clk_i = ~sys_clk_i;

	cgs_gain_sampler #(.TICK_CYCLES(TICK)) i_cgs_gain_sampler (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .cur_adc_valid_i(adc_v), .cur_adc_i(adc_d),
		.cur_valid_o(cur_v), .cur_sample_o(cur_s), .cur_pga_gain_o(ipga),
		.cur_range_o(irange), .volt_pga_gain_o(vpga), .integ_en_o(integ),
		.waveform_data_o(wave), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));

	cgs_host_model i_cgs_host_model (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .irq_n_i(irq_n),
		.irq_n_oe_i(irq_oe), .irq_line_o(irq_line));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Whole run needs a few thousand cycles at most
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// Stimulus helpers
	// ---------------------------------------------------------------
	task automatic adc(input logic [23:0] a, b, c, ea, eb, ec);
		@(negedge sys_clk_i);
		adc_v = 1'b1;
		adc_d = {c, b, a};
		@(negedge sys_clk_i);
		adc_v = 1'b0;
		adc_d = ~adc_d;
		chk(24'(cur_v), 24'h00_0001);
		chk(cur_s[0], ea);
		chk(cur_s[1], eb);
		chk(cur_s[2], ec);
	endtask

	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_line !== 1'b0 && k < 200) begin
			@(negedge sys_clk_i);
			k++;
		end
		chk(24'(irq_line), 24'h00_0000);
	endtask

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		adc_v = 1'b0;
		adc_d = '0;
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		chk(24'(irq_line), 24'h00_0001);
		// Reset values and an unmapped read
		i_cgs_host_model.rd(cgs_pkg::ADDR_GAIN, d);
		chk(24'(d), 24'(cgs_pkg::GAIN_RESET));
		i_cgs_host_model.rd(cgs_pkg::ADDR_MASK, d);
		chk(24'(d), 24'(cgs_pkg::MASK_RESET));
		i_cgs_host_model.rd(8'h7F, d);
		chk(24'(d), 24'(cgs_pkg::UNMAPPED_DATA));
		// Gain fields
		foreach (gains[i]) begin
			i_cgs_host_model.wr(cgs_pkg::ADDR_GAIN, gains[i]);
			@(negedge sys_clk_i);
			chk(24'(ipga), 24'(gains[i][1:0]));
			chk(24'(irange), 24'(gains[i][4:3]));
			chk(24'(vpga), 24'(gains[i][6:5]));
			chk(24'(integ), 24'(gains[i][7]));
			i_cgs_host_model.rd(cgs_pkg::ADDR_GAIN, d);
			chk(24'(d), 24'(gains[i]));
		end
		// Limiting at full scale, integrator, then bypass
		adc(24'h7F_FFFF, 24'h80_0000, 24'h00_0333, cgs_pkg::FS_POS, cgs_pkg::FS_NEG,
			24'h00_0333);
		i_cgs_host_model.wr(cgs_pkg::ADDR_GAIN, 8'h80);
		@(negedge sys_clk_i);
		adc(24'h00_0100, 24'h00_0000, 24'h00_0000, 24'h00_0010, 24'h00_0000,
			24'h00_0000);
		adc(24'h00_0100, 24'h00_0000, 24'h00_0000, 24'h00_001F, 24'h00_0000,
			24'h00_0000);
		i_cgs_host_model.wr(cgs_pkg::ADDR_GAIN, 8'h00);
		@(negedge sys_clk_i);
		adc(24'h11_1111, 24'h0A_BCDE, 24'hF2_3456, 24'h11_1111, 24'h0A_BCDE,
			24'hF2_3456);
		// Rates and phases
		i_cgs_host_model.wr(cgs_pkg::ADDR_MASK, 8'h01);
		for (int r = 0; r < 4; r++) begin
			i_cgs_host_model.wr(cgs_pkg::ADDR_WAVEFORM_MODE_REG, {1'b0, 2'(r), 2'(r % 3), 3'b000});
			i_cgs_host_model.ack(d);
			wait_irq();
			t0 = cyc;
			i_cgs_host_model.ack(d);
			wait_irq();
			chk(24'(cyc - t0), 24'(TICK << r));
			chk(wave, ph[r % 3]);
		end
		// Byte order, holding of the request, release by status read
		i_cgs_host_model.wr(cgs_pkg::ADDR_WAVEFORM_MODE_REG, 8'h68);
		i_cgs_host_model.ack(d);
		wait_irq();
		chk(wave, 24'h0A_BCDE);
		i_cgs_host_model.rd_sample(s);
		chk(s, 24'h0A_BCDE);
		chk(24'(irq_line), 24'h00_0000);
		i_cgs_host_model.ack(d);
		chk(24'(d), 24'h00_0001);
		chk(24'(irq_line), 24'h00_0001);
		// Masking drops the request
		wait_irq();
		i_cgs_host_model.wr(cgs_pkg::ADDR_MASK, 8'h00);
		@(negedge sys_clk_i);
		chk(24'(irq_line), 24'h00_0001);
		// Other source or phase 3 gives no samples
		i_cgs_host_model.wr(cgs_pkg::ADDR_MASK, 8'h01);
		for (int m = 0; m < 2; m++) begin
			i_cgs_host_model.wr(cgs_pkg::ADDR_WAVEFORM_MODE_REG, (m == 0) ? 8'h01 : 8'h18);
			i_cgs_host_model.ack(d);
			repeat (40) @(negedge sys_clk_i);
			chk(24'(irq_line), 24'h00_0001);
		end
		end_sim();
	end
endmodule
